// *** src/lib_int_router.sv ***
`timescale 1ns/1ns
module lib_int_router
    import lib_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Controls
    input  wire logic [1:0] step,
    input  wire logic       tie_two,
    input  wire logic       tie_all,
    // Raw interrupt lines, bit 0 is INTA
    input  wire logic [3:0] int_lines,
    // Serial interrupt slots, bit 0 is slot A
    output logic      [3:0] slot_q,
    output logic      [3:0] lines_used_q
);

    logic [3:0] merged;
    logic [3:0] slot_d;
    logic [3:0] lines_used_d;

    always_comb
    begin
        merged       = int_lines;
        lines_used_d = 4'hF;
        if (tie_all)
        begin
            merged       = {3'h0, |int_lines};
            lines_used_d = 4'h1;
        end
        else if (tie_two)
        begin
            merged       = {int_lines[3:2], 1'b0, int_lines[0] | int_lines[1]};
            lines_used_d = 4'hD;
        end
        if (step == LIB_STEP_NONE)
        begin
            slot_d = merged;
        end
        else if (step == LIB_STEP_ONE)
        begin
            slot_d = {merged[2:0], merged[3]};
        end
        else
        begin
            slot_d = {merged[1:0], merged[3:2]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            slot_q       <= 4'h0;
            lines_used_q <= 4'hF;
        end
        else
        begin
            slot_q       <= slot_d;
            lines_used_q <= lines_used_d;
        end
    end

endmodule

// *** src/lib_legacy_sysctl.sv ***
`timescale 1ns/1ns
// Operation
// - Decode base as index, base+1 as data
// - Base word aligned, bit 0 reads one
// - Base resets to 0000_0001h globally only
// - Upper control byte resets to 08h by global reset
// - Stepping field rotates serial interrupt slots
// - Bit 29 merges INTB into INTA
// - Bit 28 merges all lines onto INTA
// - Bit 27 selects power-switch clock source
// - Bit 26 routes power event: LEGACY_IRQ_LINE_TWO/CARD_STATUS_CHANGE_INTERRUPT
// - Power write with enable sets flag
// - Writing one clears flag, zero ignored
// - Enable gives SMI per power write
module lib_legacy_sysctl
    import lib_pkg::*;
#(
    parameter int LEGACY_OFS_W = 8
)
(
    // Clock and global reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // Configuration access
    input  wire logic                    cfg_wr,
    input  wire logic                    cfg_rd,
    input  wire logic [7:0]              cfg_addr,
    input  wire logic [3:0]              cfg_be,
    input  wire logic [31:0]             cfg_wdata,
    output logic      [31:0]             cfg_rdata_q,
    output logic                         cfg_ack_q,
    // I/O space access
    input  wire logic                    io_wr,
    input  wire logic                    io_rd,
    input  wire logic [31:0]             io_addr,
    input  wire logic [7:0]              io_wdata,
    output logic      [7:0]              io_rdata_q,
    output logic                         io_ack_q,
    // Legacy card register set
    output logic                         legacy_wr_q,
    output logic                         legacy_rd_q,
    output logic      [LEGACY_OFS_W-1:0] legacy_offset_q,
    output logic      [7:0]              legacy_wdata_q,
    input  wire logic [7:0]              legacy_rdata,
    // Socket power write event
    input  wire logic                    power_write,
    output logic                         smi_pulse_q,
    output logic                         legacy_irq_line_two_q,
    output logic                         card_status_change_interrupt_q,
    // Power switch clock
    output logic                         power_switch_clock_oe_q,
    // Interrupts
    input  wire logic [3:0]              int_lines,
    output logic      [3:0]              int_slot_q,
    output logic      [3:0]              int_lines_used_q
);

    // The stored offset must fit inside the byte written to the index port.
    if (LEGACY_OFS_W < 1 || LEGACY_OFS_W > 8)
    begin : g_ofs_w_check
        $error("LEGACY_OFS_W must lie in 1..8");
    end

    logic [31:0]             base_q;
    logic [31:0]             base_d;
    logic [7:0]              hi_q;
    logic [7:0]              hi_d;
    logic [LEGACY_OFS_W-1:0] index_q;
    logic [LEGACY_OFS_W-1:0] index_d;
    logic [31:0]             cfg_rdata_d;
    logic                    cfg_ack_d;
    logic [7:0]              io_rdata_d;
    logic                    io_ack_d;
    logic                    data_rd_wait_q;
    logic                    data_rd_wait_d;
    logic                    legacy_wr_d;
    logic                    legacy_rd_d;
    logic [7:0]              legacy_wdata_d;
    logic                    smi_d;
    logic                    legacy_irq_line_two_d;
    logic                    csc_d;
    logic [31:0]             index_addr;
    logic                    hit_index;
    logic                    hit_data;

    function automatic logic [31:0] lib_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    assign index_addr = {base_q[31:1], 1'b0};
    assign hit_index  = (io_addr == index_addr);
    assign hit_data   = (io_addr == 32'(index_addr + LIB_DATA_PORT_STEP));

    always_comb
    begin
        base_d      = base_q;
        hi_d        = hi_q;
        cfg_ack_d   = cfg_wr | cfg_rd;
        cfg_rdata_d = 32'h00000000;
        if (cfg_wr && cfg_addr == LIB_OFS_LEGACY_BASE)
        begin
            base_d = lib_merge(base_q, cfg_wdata, cfg_be) | LIB_BASE_FIXED_ONE;
        end
        if (cfg_wr && cfg_addr == LIB_OFS_SYS_CTRL && cfg_be[LIB_BE_HI])
        begin
            hi_d = cfg_wdata[31:24];
            hi_d[LIB_BIT_EVT_FLAG] = hi_q[LIB_BIT_EVT_FLAG]
                                     & ~cfg_wdata[LIB_HI_LSB + LIB_BIT_EVT_FLAG];
        end
        if (power_write && hi_q[LIB_BIT_EVT_ENABLE])
        begin
            hi_d[LIB_BIT_EVT_FLAG] = 1'b1;
        end
        if (cfg_rd && cfg_addr == LIB_OFS_LEGACY_BASE)
        begin
            cfg_rdata_d = base_q;
        end
        else if (cfg_rd && cfg_addr == LIB_OFS_SYS_CTRL)
        begin
            cfg_rdata_d = {hi_q, LIB_RST_SYS_CTRL[23:0]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            base_q      <= LIB_RST_LEGACY_BASE;
            hi_q        <= LIB_RST_SYS_CTRL_HI;
            cfg_rdata_q <= 32'h00000000;
            cfg_ack_q   <= 1'b0;
        end
        else
        begin
            base_q      <= base_d;
            hi_q        <= hi_d;
            cfg_rdata_q <= cfg_rdata_d;
            cfg_ack_q   <= cfg_ack_d;
        end
    end

    always_comb
    begin
        index_d        = index_q;
        legacy_wr_d    = 1'b0;
        legacy_rd_d    = 1'b0;
        legacy_wdata_d = legacy_wdata_q;
        io_ack_d       = 1'b0;
        io_rdata_d     = io_rdata_q;
        data_rd_wait_d = 1'b0;
        if (data_rd_wait_q)
        begin
            io_ack_d   = 1'b1;
            io_rdata_d = legacy_rdata;
        end
        else if (io_wr && hit_index)
        begin
            index_d  = io_wdata[LEGACY_OFS_W-1:0];
            io_ack_d = 1'b1;
        end
        else if (io_rd && hit_index)
        begin
            io_ack_d   = 1'b1;
            io_rdata_d = 8'h00;
            io_rdata_d[LEGACY_OFS_W-1:0] = index_q;
        end
        else if (io_wr && hit_data)
        begin
            legacy_wr_d    = 1'b1;
            legacy_wdata_d = io_wdata;
            io_ack_d       = 1'b1;
        end
        else if (io_rd && hit_data)
        begin
            legacy_rd_d    = 1'b1;
            data_rd_wait_d = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            index_q        <= '0;
            legacy_wr_q    <= 1'b0;
            legacy_rd_q    <= 1'b0;
            legacy_wdata_q <= 8'h00;
            io_ack_q       <= 1'b0;
            io_rdata_q     <= 8'h00;
            data_rd_wait_q <= 1'b0;
        end
        else
        begin
            index_q        <= index_d;
            legacy_wr_q    <= legacy_wr_d;
            legacy_rd_q    <= legacy_rd_d;
            legacy_wdata_q <= legacy_wdata_d;
            io_ack_q       <= io_ack_d;
            io_rdata_q     <= io_rdata_d;
            data_rd_wait_q <= data_rd_wait_d;
        end
    end

    assign legacy_offset_q = index_q;

    always_comb
    begin
        smi_d  = power_write & hi_q[LIB_BIT_EVT_ENABLE];
        legacy_irq_line_two_d = smi_d & ~hi_q[LIB_BIT_EVT_ROUTE];
        csc_d  = smi_d & hi_q[LIB_BIT_EVT_ROUTE];
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            smi_pulse_q                    <= 1'b0;
            legacy_irq_line_two_q          <= 1'b0;
            card_status_change_interrupt_q <= 1'b0;
            power_switch_clock_oe_q        <= LIB_RST_SYS_CTRL_HI[LIB_BIT_CLK_SRC];
        end
        else
        begin
            smi_pulse_q                    <= smi_d;
            legacy_irq_line_two_q          <= legacy_irq_line_two_d;
            card_status_change_interrupt_q <= csc_d;
            power_switch_clock_oe_q        <= hi_q[LIB_BIT_CLK_SRC];
        end
    end

    lib_int_router u_router
    (
        .clk          (clk),
        .reset_n      (reset_n),
        .step         (hi_q[LIB_BIT_STEP_HI:LIB_BIT_STEP_LO]),
        .tie_two      (hi_q[LIB_BIT_TIE_TWO]),
        .tie_all      (hi_q[LIB_BIT_TIE_ALL]),
        .int_lines    (int_lines),
        .slot_q       (int_slot_q),
        .lines_used_q (int_lines_used_q)
    );

endmodule

// *** src/lib_pkg.sv ***
package lib_pkg;

    // Configuration-space byte addresses.
    localparam logic [7:0]  LIB_OFS_LEGACY_BASE   = 8'h44;
    localparam logic [7:0]  LIB_OFS_SYS_CTRL      = 8'h80;

    // Reset values.
    localparam logic [31:0] LIB_RST_LEGACY_BASE   = 32'h00000001;
    localparam logic [31:0] LIB_RST_SYS_CTRL      = 32'h08449060;
    localparam logic [7:0]  LIB_RST_SYS_CTRL_HI   = 8'h08;

    // Field positions inside the system control upper byte (bits 31:24).
    localparam int          LIB_HI_LSB            = 24;
    localparam int          LIB_BIT_STEP_HI       = 7;
    localparam int          LIB_BIT_STEP_LO       = 6;
    localparam int          LIB_BIT_TIE_TWO       = 5;
    localparam int          LIB_BIT_TIE_ALL       = 4;
    localparam int          LIB_BIT_CLK_SRC       = 3;
    localparam int          LIB_BIT_EVT_ROUTE     = 2;
    localparam int          LIB_BIT_EVT_FLAG      = 1;
    localparam int          LIB_BIT_EVT_ENABLE    = 0;

    // Byte lane carrying bits 31:24.
    localparam int          LIB_BE_HI             = 3;

    // Legacy base bit that always reads as one.
    localparam logic [31:0] LIB_BASE_FIXED_ONE    = 32'h00000001;

    // Interrupt slot stepping codes.
    localparam logic [1:0]  LIB_STEP_NONE         = 2'h0;
    localparam logic [1:0]  LIB_STEP_ONE          = 2'h1;

    // Data port sits at index port plus one.
    localparam logic [31:0] LIB_DATA_PORT_STEP    = 32'h00000001;

endpackage

// *** verif/lib_legacy_sysctl_checker.sv ***
`timescale 1ns/1ns
module lib_legacy_sysctl_checker
    import lib_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Configuration and I/O
    input wire logic        cfg_rd,
    input wire logic [7:0]  cfg_addr,
    input wire logic [31:0] cfg_rdata_q,
    input wire logic        legacy_rd_q,
    input wire logic [7:0]  legacy_rdata,
    input wire logic        io_ack_q,
    input wire logic [7:0]  io_rdata_q,
    // Events and interrupts
    input wire logic        power_write,
    input wire logic        smi_pulse_q,
    input wire logic        legacy_irq_line_two_q,
    input wire logic        card_status_change_interrupt_q,
    input wire logic        power_switch_clock_oe_q,
    input wire logic [3:0]  int_lines,
    input wire logic [3:0]  int_slot_q,
    input wire logic [3:0]  int_lines_used_q
);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
chk_base_bit_one: assert property (cfg_rd && cfg_addr == 8'h44 |=> cfg_rdata_q[0])
    else $error("base bit 0 read as zero");
chk_rsvd_bit_zero: assert property (cfg_rd && cfg_addr == 8'h80 |=> !cfg_rdata_q[23])
    else $error("reserved bit read as one");
chk_smi_cause: assert property (smi_pulse_q |-> $past(power_write))
    else $error("event pulse without power write");
chk_route_one_way: assert property (smi_pulse_q |->
    legacy_irq_line_two_q ^ card_status_change_interrupt_q)
    else $error("event routed to both or neither line");
chk_reset_clk_src: assert property ($rose(reset_n) |->
    power_switch_clock_oe_q && int_slot_q == 4'h0)
    else $error("clock source not at reset value");
chk_used_mask: assert property (int_lines_used_q == 4'hF ||
    int_lines_used_q == 4'hD || int_lines_used_q == 4'h1)
    else $error("line mask not a tie arrangement");
chk_slot_idle: assert property ($past(int_lines) == 4'h0 |-> int_slot_q == 4'h0)
    else $error("slot active without line");
chk_data_read: assert property (legacy_rd_q |=>
    io_ack_q && io_rdata_q == $past(legacy_rdata))
    else $error("data read not returned");
endmodule
bind lib_legacy_sysctl lib_legacy_sysctl_checker lib_legacy_sysctl_checker_inst (.clk, .reset_n,
    .cfg_rd, .cfg_addr, .cfg_rdata_q, .legacy_rd_q, .legacy_rdata, .io_ack_q, .io_rdata_q,
    .power_write, .smi_pulse_q, .legacy_irq_line_two_q, .card_status_change_interrupt_q,
    .power_switch_clock_oe_q, .int_lines, .int_slot_q, .int_lines_used_q);

// *** verif/test_lib_legacy_sysctl.sv ***
`timescale 1ns/1ns
module test_lib_legacy_sysctl
    import lib_pkg::*;
;
logic clk = 0, reset_n = 0, cfg_wr = 0, cfg_rd = 0, io_wr = 0, io_rd = 0, power_write = 0;
logic cfg_ack_q, io_ack_q, legacy_wr_q, legacy_rd_q, smi_pulse_q, irq_two, stat_int, oe, ak;
logic [7:0]  cfg_addr = 0, io_wdata = 0, legacy_rdata = 0, io_rdata_q, legacy_offset_q;
logic [7:0]  legacy_wdata_q, u;
logic [3:0]  cfg_be = 0, int_lines = 0, int_slot_q, int_lines_used_q, b;
logic [31:0] cfg_wdata = 0, io_addr = 0, cfg_rdata_q, rd, base, w;
int          err_count = 0, tests_run = 0, seed, i, j;
always #2 clk = ~clk;
lib_legacy_sysctl lib_legacy_sysctl_inst (.clk, .reset_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
    .cfg_wdata, .cfg_rdata_q, .cfg_ack_q, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata_q,
    .io_ack_q, .legacy_wr_q, .legacy_rd_q, .legacy_offset_q, .legacy_wdata_q, .legacy_rdata,
    .power_write, .smi_pulse_q, .legacy_irq_line_two_q(irq_two),
    .card_status_change_interrupt_q(stat_int), .power_switch_clock_oe_q(oe), .int_lines,
    .int_slot_q, .int_lines_used_q);
task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
        err_count++;
        $display("wrong value %s expected %h seen %h", name, exp, got);
    end
endtask
task automatic stop_test();
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task automatic cfg(logic wr, logic [7:0] a, logic [3:0] be, logic [31:0] d);
    @(posedge clk);
    #1;
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {wr, !wr, a, be, d};
    @(posedge clk);
    #1;
    {cfg_wr, cfg_rd} = 2'h0;
    rd = cfg_rdata_q;
    check("cfg ack", 1, cfg_ack_q);
endtask
// A data-port read answers one cycle later than the other I/O accesses.
task automatic io(logic wr, logic [31:0] a, logic [7:0] d);
    @(posedge clk);
    #1;
    {io_wr, io_rd, io_addr, io_wdata} = {wr, !wr, a, d};
    @(posedge clk);
    #1;
    {io_wr, io_rd} = 2'h0;
    if (!wr && a == {base[31:1], 1'h1})
    begin
        @(posedge clk);
        #1;
    end
    rd = io_rdata_q;
    ak = io_ack_q;
endtask
task automatic reset_values();
    cfg(0, 8'h44, 4'hF, 0);
    check("base", LIB_RST_LEGACY_BASE, rd);
    cfg(0, 8'h80, 4'hF, 0);
    check("control", LIB_RST_SYS_CTRL, rd);
    check("clock oe", 1, oe);
    base = LIB_RST_LEGACY_BASE;
endtask
function automatic logic [3:0] slots(logic [7:0] c, logic [3:0] l);
    logic [3:0] t;
    logic [7:0] r;
    t = c[4] ? {3'h0, |l} : c[5] ? {l[3:2], 1'h0, |l[1:0]} : l;
    r = {t, t} << (c[7:6] == 2'h3 ? 2'h2 : c[7:6]);
    return r[7:4];
endfunction
initial
begin
    #20000;
    err_count++;
    stop_test();
end
initial
begin
    seed = $urandom(32'h4c89);
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1;
    reset_values();
    for (i = 0; i < 4; i++)
    begin
        w = $urandom;
        b = (i == 3) ? 4'hF : 4'($urandom);
        cfg(1, 8'h44, b, w);
        for (j = 0; j < 4; j++)
            if (b[j])
                base[8*j+:8] = w[8*j+:8];
        base[0] = 1'h1;
        cfg(0, 8'h44, 4'hF, 0);
        check("base", base, rd);
    end
    io(1, {base[31:1], 1'h0}, w[7:0]);
    check("index ack", 1, ak);
    io(0, {base[31:1], 1'h0}, 0);
    check("index", w[7:0], rd);
    legacy_rdata = 8'($urandom);
    io(1, {base[31:1], 1'h1}, w[15:8]);
    check("legacy write", {1'h1, w[7:0], w[15:8]},
          {legacy_wr_q, legacy_offset_q, legacy_wdata_q});
    io(0, {base[31:1], 1'h1}, 0);
    check("data read", legacy_rdata, rd);
    check("data ack", 1, ak);
    io(1, {base[31:1], 1'h0} + 32'h2, 0);
    check("miss ack", 0, ak);
    cfg(1, 8'h48, 4'hF, w);
    cfg(0, 8'h48, 4'hF, 0);
    check("unmapped", 0, rd);
    for (i = 0; i < 16; i++)
    begin
        u = {i[1:0], i[3:2], 1'($urandom), 3'h0};
        cfg(1, 8'h80, 4'h8, {u, 24'h0});
        cfg(1, 8'h80, 4'h7, 32'hFFFFFFFF);
        int_lines = 4'($urandom);
        repeat (2) @(posedge clk);
        #1;
        check("slots", slots(u, int_lines), int_slot_q);
        check("used", u[4] ? 4'h1 : u[5] ? 4'hD : 4'hF, int_lines_used_q);
        check("clock oe", u[3], oe);
        cfg(0, 8'h80, 4'hF, 0);
        check("control", {u, LIB_RST_SYS_CTRL[23:0]}, rd);
    end
    for (i = 0; i < 3; i++)
    begin
        u = {5'h0, i[1], 1'h0, i != 0};
        cfg(1, 8'h80, 4'h8, {u, 24'h0});
        power_write = 1;
        @(posedge clk);
        #1;
        power_write = 0;
        check("smi", i != 0, smi_pulse_q);
        check("route", {i == 2, i == 1}, {stat_int, irq_two});
        cfg(1, 8'h80, 4'h8, {u, 24'h0});
        cfg(0, 8'h80, 4'hF, 0);
        check("flag", i != 0, rd[25]);
        cfg(1, 8'h80, 4'h8, {u | 8'h02, 24'h0});
        cfg(0, 8'h80, 4'hF, 0);
        check("flag clear", 0, rd[25]);
    end
    reset_n = 0;
    @(posedge clk);
    #1;
    reset_n = 1;
    reset_values();
    stop_test();
end
endmodule
